// [logic/wd_count_if.sv]
// Interface between watchdog control and its time-out counter
`timescale 1ns/1ps
interface wd_count_if;
	logic       ce;
	logic       clr;
	logic       tick;
	logic [3:0] code;
	logic       timeout;

	modport ctl (output ce, output clr, output tick, output code, input timeout);
	modport cnt (input ce, input clr, input tick, input code, output timeout);
endinterface

// [logic/wd_counter.sv]
// Watchdog time-out counter running on oscillator ticks
`timescale 1ns/1ps
module wd_counter
	import wd_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control side
	wd_count_if.cnt   cif
);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic             timeout_r;
	logic             timeout_nxt;
	logic [CNT_W-1:0] limit;

	assign cif.timeout = timeout_r;

	always_comb begin
		limit       = CNT_W'((BASE_CYCLES << cif.code) - 21'h1);
		count_nxt   = count_r;
		timeout_nxt = 1'b0;
		if (cif.clr) begin
			count_nxt = '0;
		end else if (cif.tick) begin
			if (count_r >= limit) begin
				count_nxt   = '0;
				timeout_nxt = 1'b1;
			end else begin
				count_nxt = CNT_W'(count_r + 21'h1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_r   <= '0;
			timeout_r <= 1'b0;
		end else if (cif.ce) begin
			count_r   <= count_nxt;
			timeout_r <= timeout_nxt;
		end
	end

endmodule

// [logic/wd_pkg.sv]
// Package with watchdog register map, fields and timing constants
package wd_pkg;

	// Bus geometry
	localparam int          WB_ADR_W       = 8;
	localparam int          WB_DAT_W       = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  CTRL_IDX       = 8'h21;
	localparam logic [7:0]  STAT_IDX       = 8'h22;
	localparam logic [7:0]  CTRL_ADDR      = 8'(CTRL_IDX * 4);
	localparam logic [7:0]  STAT_ADDR      = 8'(STAT_IDX * 4);

	// Control register fields
	localparam int          CTRL_WD_TIMEOUT_FLAG      = 7;
	localparam int          CTRL_WD_INTERRUPT_ENABLE      = 6;
	localparam int          CTRL_WDP3      = 5;
	localparam int          CTRL_WD_CHANGE_ENABLE      = 4;
	localparam int          CTRL_WDE       = 3;
	localparam int          CTRL_WDP_LO    = 0;

	// Status register fields
	localparam int          STAT_WD_RESET_CAUSE_FLAG      = 3;
	localparam int          STAT_BROWNOUT_CAUSE_FLAG      = 2;
	localparam int          STAT_EXTERNAL_RESET_CAUSE_FLAG     = 1;
	localparam int          STAT_POWERON_CAUSE_FLAG      = 0;

	// Values after reset
	localparam logic [7:0]  STAT_POR_VAL   = 8'h01;
	localparam logic [3:0]  WDP_RST_VAL    = 4'h0;

	// Oscillator and time-out lengths
	localparam int          WD_OSC_KHZ     = 128;
	localparam int          CNT_W          = 21;
	localparam logic [20:0] BASE_CYCLES    = 21'h000800;
	localparam logic [3:0]  MAX_CODE       = 4'h9;

	// Change window length in system clock cycles
	localparam logic [2:0]  WD_CHANGE_ENABLE_CYCLES    = 3'h4;

	// Change window states
	typedef enum logic {
		SEQ_IDLE,
		SEQ_OPEN
	} seq_state_t;

endpackage

// [logic/wd_top.sv]
// Watchdog with reset cause flags and Wishbone register slave
//
// Function
// - Counter advances on 128 kHz oscillator ticks
// - Restart, disable or chip reset clears counter
// - Ten periods; expiry with reset action resets
// - Lock fuse selects safety level one or two
// - Level one: writing enable one always enables
// - Level two: always running, enable reads one
// - Level two period change by timed two writes
// - Status upper four bits read zero
// - Reset flags set by source, cleared writing zero
// - Power-on flag cleared only by writing zero
// - Time-out flag set; cleared by vector or one
// - Interrupt needs global and watchdog enables
// - Enable and interrupt-enable choose time-out action
// - Time-out clears interrupt-enable when enable set
// - Clear or level two period change needs change-enable; four-cycle
// - Code picks 2048 to 1048576 cycles, doubling
// - Level one: reset flag forces enable on
// - Watchdog reset is a one-cycle pulse
`timescale 1ns/1ps
module wd_top
	import wd_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [WB_DAT_W-1:0] wb_dat_i,
	output logic      [WB_DAT_W-1:0] wb_dat_o,
	output logic                     wb_ack_o,
	// Chip side
	input  wire logic                watchdog_lock_fuse_i,
	input  wire logic                wd_osc_i,
	input  wire logic                wd_restart_i,
	input  wire logic                global_int_en_i,
	input  wire logic                wd_vector_taken_i,
	input  wire logic                ext_reset_i,
	input  wire logic                brownout_reset_i,
	// Outputs
	output logic                     wd_irq_o,
	output logic                     wd_reset_o
);

	wd_count_if cif ();

	// Bus state
	logic                ack_r;
	logic                ack_nxt;
	logic [WB_DAT_W-1:0] rdat_r;
	logic [WB_DAT_W-1:0] rdat_nxt;

	// Control state
	logic                wd_timeout_flag_r;
	logic                wd_timeout_flag_nxt;
	logic                wd_interrupt_enable_r;
	logic                wd_interrupt_enable_nxt;
	logic                wd_enable_bit_r;
	logic                wd_enable_bit_nxt;
	logic [3:0]          wd_prescale_code_r;
	logic [3:0]          wd_prescale_code_nxt;
	seq_state_t          seq_r;
	seq_state_t          seq_nxt;
	logic [2:0]          win_cnt_r;
	logic [2:0]          win_cnt_nxt;
	logic                wd_rst_r;
	logic                wd_rst_nxt;
	logic                irq_r;
	logic                irq_nxt;

	// Status and oscillator state
	logic [3:0]          cause_r;
	logic [3:0]          cause_nxt;
	logic                osc_q_r;
	logic                osc_q_nxt;

	// Derived terms
	logic                req;
	logic                wr_ctrl;
	logic                wr_stat;
	logic [7:0]          wd;
	logic                chip_rst;
	logic                eff_enable;
	logic                running;
	logic                win_open;
	logic [7:0]          ctrl_view;

	assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wd       = wb_dat_i[7:0];
	assign wr_ctrl  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == CTRL_ADDR);
	assign wr_stat  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == STAT_ADDR);
	assign chip_rst = ext_reset_i | brownout_reset_i | wd_rst_r;
	assign win_open = (seq_r == SEQ_OPEN);

	assign eff_enable = wd_enable_bit_r | watchdog_lock_fuse_i | cause_r[STAT_WD_RESET_CAUSE_FLAG];

	assign running = eff_enable | wd_interrupt_enable_r;

	assign ctrl_view = {wd_timeout_flag_r, wd_interrupt_enable_r, wd_prescale_code_r[3],
		win_open, eff_enable, wd_prescale_code_r[2:0]};

	// Counter hookup
	assign cif.ce   = ce_i;
	assign cif.tick = wd_osc_i & ~osc_q_r;
	assign cif.clr  = wd_restart_i | chip_rst | ~running;
	assign cif.code = (wd_prescale_code_r > MAX_CODE) ? MAX_CODE : wd_prescale_code_r;

	wd_counter u_counter (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cif   (cif)
	);

	assign wb_ack_o   = ack_r;
	assign wb_dat_o   = rdat_r;
	assign wd_irq_o   = irq_r;
	assign wd_reset_o = wd_rst_r;

	// Bus answer
	always_comb begin
		ack_nxt  = req;
		rdat_nxt = '0;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				CTRL_ADDR: begin
					rdat_nxt = {24'h0, ctrl_view};
				end
				STAT_ADDR: begin
					rdat_nxt = {28'h0, cause_r};
				end
				default: begin
					rdat_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end else if (ce_i) begin
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	// Control register and change window
	always_comb begin
		wd_timeout_flag_nxt     = wd_timeout_flag_r;
		wd_interrupt_enable_nxt = wd_interrupt_enable_r;
		wd_enable_bit_nxt       = wd_enable_bit_r;
		wd_prescale_code_nxt    = wd_prescale_code_r;
		seq_nxt                 = seq_r;
		win_cnt_nxt             = win_cnt_r;
		wd_rst_nxt              = 1'b0;
		irq_nxt                 = 1'b0;
		if (chip_rst) begin
			wd_timeout_flag_nxt     = 1'b0;
			wd_interrupt_enable_nxt = 1'b0;
			wd_enable_bit_nxt       = 1'b0;
			wd_prescale_code_nxt    = WDP_RST_VAL;
			seq_nxt                 = SEQ_IDLE;
			win_cnt_nxt             = '0;
		end else begin
			if (win_open) begin
				win_cnt_nxt = 3'(win_cnt_r - 3'h1);
				if (win_cnt_r == 3'h1) begin
					seq_nxt = SEQ_IDLE;
				end
			end
			if (wr_ctrl) begin
				wd_interrupt_enable_nxt = wd[CTRL_WD_INTERRUPT_ENABLE];
				if (wd[CTRL_WD_TIMEOUT_FLAG]) begin
					wd_timeout_flag_nxt = 1'b0;
				end
				if (wd[CTRL_WD_CHANGE_ENABLE] && wd[CTRL_WDE]) begin
					seq_nxt           = SEQ_OPEN;
					win_cnt_nxt       = WD_CHANGE_ENABLE_CYCLES;
					wd_enable_bit_nxt = 1'b1;
				end else begin
					if (wd[CTRL_WDE]) begin
						wd_enable_bit_nxt = 1'b1;
					end else if (win_open) begin
						wd_enable_bit_nxt = 1'b0;
					end
					if (win_open || !watchdog_lock_fuse_i) begin
						wd_prescale_code_nxt = {wd[CTRL_WDP3], wd[CTRL_WDP_LO +: 3]};
					end
					if (win_open) begin
						seq_nxt     = SEQ_IDLE;
						win_cnt_nxt = '0;
					end
				end
			end
			if (wd_vector_taken_i) begin
				wd_timeout_flag_nxt = 1'b0;
			end
			if (cif.timeout) begin
				if (wd_interrupt_enable_r) begin
					wd_timeout_flag_nxt = 1'b1;
					if (eff_enable) begin
						wd_interrupt_enable_nxt = 1'b0;
					end
				end else if (eff_enable) begin
					wd_rst_nxt = 1'b1;
				end
			end
		end
		irq_nxt = wd_timeout_flag_nxt & wd_interrupt_enable_r & global_int_en_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_timeout_flag_r     <= 1'b0;
			wd_interrupt_enable_r <= 1'b0;
			wd_enable_bit_r       <= 1'b0;
			wd_prescale_code_r    <= WDP_RST_VAL;
			seq_r                 <= SEQ_IDLE;
			win_cnt_r             <= '0;
			wd_rst_r              <= 1'b0;
			irq_r                 <= 1'b0;
		end else if (ce_i) begin
			wd_timeout_flag_r     <= wd_timeout_flag_nxt;
			wd_interrupt_enable_r <= wd_interrupt_enable_nxt;
			wd_enable_bit_r       <= wd_enable_bit_nxt;
			wd_prescale_code_r    <= wd_prescale_code_nxt;
			seq_r                 <= seq_nxt;
			win_cnt_r             <= win_cnt_nxt;
			wd_rst_r              <= wd_rst_nxt;
			irq_r                 <= irq_nxt;
		end
	end

	// Reset cause flags and oscillator edge
	always_comb begin
		cause_nxt = cause_r;
		osc_q_nxt = wd_osc_i;
		if (wr_stat) begin
			cause_nxt = cause_r & wd[3:0];
		end
		if (wd_rst_r) begin
			cause_nxt[STAT_WD_RESET_CAUSE_FLAG] = 1'b1;
		end
		if (brownout_reset_i) begin
			cause_nxt[STAT_BROWNOUT_CAUSE_FLAG] = 1'b1;
		end
		if (ext_reset_i) begin
			cause_nxt[STAT_EXTERNAL_RESET_CAUSE_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cause_r <= STAT_POR_VAL[3:0];
			osc_q_r <= 1'b0;
		end else if (ce_i) begin
			cause_r <= cause_nxt;
			osc_q_r <= osc_q_nxt;
		end
	end

endmodule

// [verif/wd_top_checker.sv]
// Assertion checker for the watchdog top ports
`timescale 1ns/1ps
module wd_top_checker
	import wd_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Bus
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [WB_DAT_W-1:0] wb_dat_o,
	input  wire logic                wb_ack_o,
	// Chip side
	input  wire logic                global_int_en_i,
	input  wire logic                wd_irq_o,
	input  wire logic                wd_reset_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_stat_rsvd: assert property (
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == STAT_ADDR |-> wb_dat_o[7:4] == 4'h0)
		else $error("status reserved bits set");
	chk_unmap_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) != CTRL_ADDR
		&& $past(wb_adr_i) != STAT_ADDR |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_rst_pulse: assert property (wd_reset_o |=> !wd_reset_o)
		else $error("watchdog reset longer than one cycle");
	chk_irq_gate: assert property (wd_irq_o |-> $past(global_int_en_i))
		else $error("interrupt without global enable");
endmodule

bind wd_top wd_top_checker u_chk (.*);

// [verif/wd_top_tb.sv]
// Self-checking bench for the watchdog top
`timescale 1ns/1ps
module wd_top_tb
	import wd_pkg::*;
;
	logic        clk_i, rst_i, cyc, we, gie, osc, irq, wrst, ack, ext, bor, vec, fuse;
	logic [7:0]  adr, q;
	logic [31:0] dat, rdat;
	int          err_count, total_checks, cyc_n, n, r, c, stat_m;

	wd_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .watchdog_lock_fuse_i(fuse), .wd_osc_i(osc), .wd_restart_i(1'b0),
		.global_int_en_i(gie), .wd_vector_taken_i(vec), .ext_reset_i(ext),
		.brownout_reset_i(bor), .wd_irq_o(irq), .wd_reset_o(wrst));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Oscillator tick every second clock
	always @(posedge clk_i) begin
		osc <= ~osc;
		cyc_n <= cyc_n + 1;
		if (cyc_n == 40000) begin
			err_count++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat[7:0];
		cyc <= 1'b0;
		@(posedge clk_i);
		if (k == 50)
			err_count++;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		check(q, e);
	endtask

	task automatic pulse(input int s);
		ext <= (s == 0);
		bor <= (s == 1);
		vec <= (s == 2);
		stat_m |= (s < 2) ? (2 << s) : 0;
		@(posedge clk_i);
		{ext, bor, vec} <= 3'h0;
		@(posedge clk_i);
	endtask

	task automatic waitfor(input logic s);
		n = 0;
		while ((s ? wrst : irq) !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	initial begin
		{cyc, we, gie, osc, ext, bor, vec, fuse} = 8'h0;
		adr = 8'h00;
		dat = 32'h0;
		{err_count, total_checks, cyc_n, stat_m} = {32'd0, 32'd0, 32'd0, 32'd1};
		rst_i = 1'b1;
		r = $urandom(4);
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Power-on state and flags
		rd(STAT_ADDR, 8'h01);
		rd(CTRL_ADDR, 8'h00);
		rd(8'h10, 8'h00);
		wb(1'b1, STAT_ADDR, 8'hff);
		rd(STAT_ADDR, 8'h01);
		wb(1'b1, STAT_ADDR, 8'h00);
		stat_m = 0;
		rd(STAT_ADDR, 8'h00);
		pulse(0);
		rd(STAT_ADDR, stat_m[7:0]);
		pulse(1);
		rd(STAT_ADDR, stat_m[7:0]);
		wb(1'b1, STAT_ADDR, 8'h00);
		stat_m = 0;
		$display("flags test done");
		// Every code, then a reserved one
		r = $urandom_range(9);
		for (int i = 0; i < 11; i++) begin
			c = (i < 10) ? (i + r) % 10 : 10 + $urandom_range(5);
			wb(1'b1, CTRL_ADDR, {2'h0, c[3], 2'h0, c[2:0]});
			rd(CTRL_ADDR, {2'h0, c[3], 2'h0, c[2:0]});
		end
		wb(1'b1, CTRL_ADDR, 8'h00);
		$display("prescaler test done");
		// Enable and timed disable
		wb(1'b1, CTRL_ADDR, 8'h08);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h18);
		repeat (6) @(posedge clk_i);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h18);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h00);
		$display("disable test done");
		// Interrupt-only time-out
		gie <= 1'b1;
		wb(1'b1, CTRL_ADDR, 8'h40);
		waitfor(1'b0);
		check({7'h0, n > 2 * BASE_CYCLES - 8 && n < 2 * BASE_CYCLES + 64}, 8'h01);
		rd(CTRL_ADDR, 8'hc0);
		pulse(2);
		rd(CTRL_ADDR, 8'h40);
		wb(1'b1, CTRL_ADDR, 8'h00);
		// Interrupt, then reset
		wb(1'b1, CTRL_ADDR, 8'h48);
		waitfor(1'b0);
		rd(CTRL_ADDR, 8'h88);
		wb(1'b1, CTRL_ADDR, 8'h80);
		rd(CTRL_ADDR, 8'h08);
		waitfor(1'b1);
		check({7'h0, n < 9000}, 8'h01);
		repeat (3) @(posedge clk_i);
		stat_m |= 8;
		rd(STAT_ADDR, stat_m[7:0]);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h18);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, STAT_ADDR, 8'h00);
		wb(1'b1, CTRL_ADDR, 8'h18);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h00);
		$display("time-out test done");
		// Level two after a mid-run reset
		fuse <= 1'b1;
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(STAT_ADDR, 8'h01);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h01);
		rd(CTRL_ADDR, 8'h08);
		wb(1'b1, CTRL_ADDR, 8'h18);
		wb(1'b1, CTRL_ADDR, 8'h01);
		rd(CTRL_ADDR, 8'h09);
		$display("level two test done");
		summarize();
	end
endmodule
